// >>> src/scfd_top.sv
// Purpose: Control logic for a single-coil brushless fan drive.
// Assumes: Hall and command pins asynchronous; min speed is a digital level.
// Notes: Long timers are parameters so simulation can shorten them.
// Summary of operation
// [RULE1] Command duty is measured for input frequencies from 100 Hz to 100 kHz.
// [RULE2] The coil pulse rate is fixed and above the audible band.
// [RULE3] Coil duty follows the measured input duty within two percent.
// [RULE4] A floating command line reads high and gives full speed.
// [RULE5] Polarity changes are softened by ramping duty, not voltage.
// [RULE6] Slope length is one eighth of the torque period, clamped to 300..4000 us.
// [RULE7] Start-up adds 30 percent overdrive for about one second.
// [RULE8] Rotation is detected after four Hall edges during start-up.
// [RULE9] After rotation is seen the overdrive is dropped and duty tracks the command.
// [RULE10] The minimum speed input sets a floor on coil duty.
// [RULE11] Without the floor duty spans 0..100 percent, with it 10..100 percent.
// [RULE12] A locked-rotor retry drives the bridge for about one second.
// [RULE13] After a failed retry the bridge is off for about four seconds.
// [RULE14] South pole: coil A low, coil B high, tach low; north pole the opposite.
// [RULE15] The open-drain tach output follows the detected pole.
// [RULE16] No Hall edge during an on interval declares a locked rotor; retries repeat.
`timescale 1ns/10ps
module scfd_top import scfd_pkg::*; #(
  parameter int unsigned START_CYC = START_MS * (SYS_CLK_HZ / 1000),
  parameter int unsigned LOCK_ON_CYC = LOCK_ON_MS * (SYS_CLK_HZ / 1000),
  parameter int unsigned LOCK_OFF_CYC = LOCK_OFF_MS * (SYS_CLK_HZ / 1000),
  parameter int unsigned IN_TIMEOUT = IN_TIMEOUT_CYC
) (
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  input wire logic i_speed_cmd,
  input wire logic i_hall_south,
  input wire logic i_min_speed_in,
  output logic o_coil_drive_a,
  output logic o_coil_drive_b,
  output logic o_tach_out_oe
);
  // ****************************************
  // Input synchronisers
  // ****************************************
  // Three stages; a change counts only when stages two and three agree.
  logic [2:0] cmd_s_q, hall_s_q, min_s_q;
  logic cmd_q, hall_q, min_q;
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cmd_s_q <= 3'h7;
      hall_s_q <= 3'h0;
      min_s_q <= 3'h0;
      cmd_q <= 1'b1;
      hall_q <= 1'b0;
      min_q <= 1'b0;
    end else begin
      cmd_s_q <= {cmd_s_q[1:0], i_speed_cmd};
      hall_s_q <= {hall_s_q[1:0], i_hall_south};
      min_s_q <= {min_s_q[1:0], i_min_speed_in};
      if (cmd_s_q[1] == cmd_s_q[2]) cmd_q <= cmd_s_q[2];
      if (hall_s_q[1] == hall_s_q[2]) hall_q <= hall_s_q[2];
      if (min_s_q[1] == min_s_q[2]) min_q <= min_s_q[2];
    end
  end

  logic [DUTY_W-1:0] in_duty;
  scfd_duty_meter #(.TIMEOUT_CYC(IN_TIMEOUT)) scfd_duty_meter_inst (
    .i_sys_clk(i_sys_clk),
    .i_reset_n(i_reset_n),
    .i_cmd(cmd_q),
    .o_duty(in_duty)
  );

  // ****************************************
  // Pole edges and torque period
  // ****************************************
  logic pole_q;
  logic [CNT_W-1:0] torque_q, slope_q;
  wire pole_edge = hall_q ^ pole_q;
  wire [CNT_W-1:0] slope_raw = torque_q >> SLOPE_RATIO_SHIFT;
  wire [CNT_W-1:0] slope_lim = (slope_raw < CNT_W'(SLOPE_MIN_CYC)) ? CNT_W'(SLOPE_MIN_CYC) :
                               (slope_raw > CNT_W'(SLOPE_MAX_CYC)) ? CNT_W'(SLOPE_MAX_CYC) : slope_raw;
  logic [CNT_W-1:0] slope_len_q;
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pole_q <= 1'b0;
      torque_q <= '0;
      slope_q <= '0;
      slope_len_q <= CNT_W'(SLOPE_MIN_CYC);
    end else begin
      pole_q <= hall_q;
      if (pole_edge) begin
        torque_q <= '0;
        slope_len_q <= slope_lim; // RULE6
        slope_q <= '0;
      end else begin
        if (torque_q != '1) torque_q <= torque_q + 1'b1;
        if (slope_q < slope_len_q) slope_q <= slope_q + 1'b1;
      end
    end
  end

  // ****************************************
  // Control state machine
  // ****************************************
  scfd_state_t state_q, state_d;
  logic [CNT_W-1:0] tmr_q;
  logic [2:0] edges_q;
  wire start_done = tmr_q >= CNT_W'(START_CYC);
  wire on_done = tmr_q >= CNT_W'(LOCK_ON_CYC);
  wire off_done = tmr_q >= CNT_W'(LOCK_OFF_CYC);
  wire rot_seen = edges_q >= 3'(START_EDGES);
  always_comb begin
    state_d = state_q;
    case (state_q)
      SCFD_START: begin
        if (rot_seen) state_d = SCFD_RUN; // RULE8
        else if (start_done) state_d = SCFD_LOCK_OFF; // RULE16
      end
      SCFD_RUN: begin
        // The timer restarts on every pole edge here, so an expired on interval means a stalled rotor.
        if (on_done) state_d = SCFD_LOCK_OFF; // RULE16
      end
      SCFD_LOCK_OFF: begin
        if (off_done) state_d = SCFD_LOCK_ON; // RULE13
      end
      SCFD_LOCK_ON: begin
        if (rot_seen) state_d = SCFD_RUN;
        else if (on_done) state_d = SCFD_LOCK_OFF; // RULE12
      end
      default: state_d = SCFD_START;
    endcase
  end

  // Timer restarts on each state change and, in run, on each pole edge.
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_q <= SCFD_START;
      tmr_q <= '0;
      edges_q <= '0;
    end else begin
      state_q <= state_d;
      if (state_d != state_q || (state_q == SCFD_RUN && pole_edge)) tmr_q <= '0;
      else tmr_q <= tmr_q + 1'b1;
      if (state_d != state_q) edges_q <= '0;
      else if (pole_edge && !rot_seen) edges_q <= edges_q + 1'b1;
    end
  end

  // ****************************************
  // Duty target and output PWM
  // ****************************************
  wire boosting = (state_q == SCFD_START) || (state_q == SCFD_LOCK_ON);
  wire [DUTY_W:0] boost_sum = {1'b0, in_duty} + {1'b0, OVERDRIVE};
  wire [DUTY_W-1:0] boosted = (boost_sum > {1'b0, DUTY_FULL}) ? DUTY_FULL : boost_sum[DUTY_W-1:0];
  wire [DUTY_W-1:0] cmd_eff = boosting ? boosted : in_duty; // RULE7 RULE9
  wire [DUTY_W-1:0] floored = (min_q && cmd_eff < DUTY_TEN) ? DUTY_TEN : cmd_eff; // RULE10 RULE11
  wire bridge_off = state_q == SCFD_LOCK_OFF;
  // Ramp duty from zero across the slope after each polarity change.
  wire [CNT_W+9:0] ramp_prod = (CNT_W+10)'(floored) * (CNT_W+10)'(slope_q);
  wire [DUTY_W-1:0] ramp = DUTY_W'(ramp_prod / (CNT_W+10)'(slope_len_q));
  wire [DUTY_W-1:0] target = bridge_off ? '0 : ramp; // RULE5

  // Fixed-rate carrier independent of the command frequency; step = 1/1000 period.
  logic [3:0] step_q;
  logic [DUTY_W-1:0] phase_q;
  logic a_q, b_q, tach_q;
  wire on_phase = phase_q < target; // RULE3
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      step_q <= '0;
      phase_q <= '0;
      a_q <= 1'b0;
      b_q <= 1'b0;
      tach_q <= 1'b0;
    end else begin
      step_q <= (step_q == OUT_STEP_LAST) ? '0 : step_q + 1'b1;
      if (step_q == OUT_STEP_LAST) begin // RULE2
        phase_q <= (phase_q == DUTY_FULL - 1'b1) ? '0 : phase_q + 1'b1;
      end
      a_q <= on_phase & ~pole_q; // RULE14
      b_q <= on_phase & pole_q;
      tach_q <= pole_q; // RULE15
    end
  end

  assign o_coil_drive_a = a_q;
  assign o_coil_drive_b = b_q;
  assign o_tach_out_oe = tach_q;

  // ****************************************
  // Checks
  // ****************************************
  // The bridge must stay dark once the off interval has begun.
  property p_off_quiet;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
    (state_q == SCFD_LOCK_OFF) ##1 (state_q == SCFD_LOCK_OFF) |-> !a_q && !b_q;
  endproperty
  a_off_quiet: assert property (p_off_quiet) else $error("Bridge driven while off."); // RULE13

  // Driving both coil ends at once would short the bridge.
  property p_not_both;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
    !(a_q && b_q);
  endproperty
  a_not_both: assert property (p_not_both) else $error("Both coil outputs high."); // RULE14

  property p_tach_pole;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
    o_tach_out_oe == $past(pole_q);
  endproperty
  a_tach_pole: assert property (p_tach_pole) else $error("Tach does not follow pole."); // RULE15

  property p_south_b;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
    $past(pole_q) |-> !a_q;
  endproperty
  a_south_b: assert property (p_south_b) else $error("Coil A high on south pole."); // RULE14

  // Four edges in the start window hand over to normal running.
  property p_start_rot;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
    (state_q == SCFD_START && rot_seen) |=> state_q == SCFD_RUN;
  endproperty
  a_start_rot: assert property (p_start_rot) else $error("Rotation not detected."); // RULE8

  property p_on_end;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
    (state_q == SCFD_LOCK_ON && on_done && !rot_seen) |=> state_q == SCFD_LOCK_OFF;
  endproperty
  a_on_end: assert property (p_on_end) else $error("On interval overran."); // RULE12

  property p_slope_rng;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
    slope_len_q >= CNT_W'(SLOPE_MIN_CYC) && slope_len_q <= CNT_W'(SLOPE_MAX_CYC);
  endproperty
  a_slope_rng: assert property (p_slope_rng) else $error("Slope out of range."); // RULE6

  property p_floor;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
    min_q |-> floored >= DUTY_TEN;
  endproperty
  a_floor: assert property (p_floor) else $error("Floor not applied."); // RULE10

  // While starting, a command with headroom gets exactly the overdrive added.
  property p_boost;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
    (boosting && in_duty <= DUTY_FULL - OVERDRIVE) |-> cmd_eff == in_duty + OVERDRIVE;
  endproperty
  a_boost: assert property (p_boost) else $error("Start overdrive wrong."); // RULE7

  property p_run_plain;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
    (state_q == SCFD_RUN) |-> cmd_eff == in_duty;
  endproperty
  a_run_plain: assert property (p_run_plain) else $error("Overdrive kept after start."); // RULE9

  // The ramp may only soften the duty, never exceed the floored command.
  property p_ramp_cap;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
    !bridge_off |-> target <= floored;
  endproperty
  a_ramp_cap: assert property (p_ramp_cap) else $error("Ramp above command."); // RULE5
endmodule

// >>> src/scfd_pkg.sv
// Purpose: Shared constants and types for the single-coil fan drive control.
// Assumes: 100 MHz system clock.
// Notes: Times are given in their own unit; cycle counts derive from them.
package scfd_pkg;
  // ****************************************
  // Clock and timing
  // ****************************************
  localparam int unsigned SYS_CLK_HZ = 100_000_000;
  localparam int unsigned DUTY_W = 10;               // Duty in 1/1000 steps.
  localparam logic [DUTY_W-1:0] DUTY_FULL = 10'h3e8; // 1000 = 100 percent.
  localparam logic [DUTY_W-1:0] DUTY_TEN = 10'h064;  // 100 = 10 percent.
  localparam logic [DUTY_W-1:0] OVERDRIVE = 10'h12c; // 300 = 30 percent.
  localparam int unsigned OUT_PWM_HZ = 25_000;       // Above the audible band.
  localparam int unsigned OUT_STEP_CYC = SYS_CLK_HZ / (OUT_PWM_HZ * 1000);
  localparam logic [3:0] OUT_STEP_LAST = 4'(OUT_STEP_CYC - 1);
  localparam int unsigned IN_MIN_HZ = 100;
  localparam int unsigned IN_TIMEOUT_CYC = 2 * SYS_CLK_HZ / IN_MIN_HZ;
  localparam int unsigned SLOPE_MIN_US = 300;
  localparam int unsigned SLOPE_MAX_US = 4000;
  localparam int unsigned SLOPE_MIN_CYC = SLOPE_MIN_US * (SYS_CLK_HZ / 1_000_000);
  localparam int unsigned SLOPE_MAX_CYC = SLOPE_MAX_US * (SYS_CLK_HZ / 1_000_000);
  localparam int unsigned SLOPE_RATIO_SHIFT = 3;     // 12.5 percent is one eighth.
  localparam int unsigned START_MS = 1000;
  localparam int unsigned LOCK_ON_MS = 1000;
  localparam int unsigned LOCK_OFF_MS = 4000;
  localparam int unsigned START_EDGES = 4;
  localparam int unsigned CNT_W = 32;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {
    SCFD_START = 2'b00,
    SCFD_RUN = 2'b01,
    SCFD_LOCK_OFF = 2'b11,
    SCFD_LOCK_ON = 2'b10
  } scfd_state_t;

  typedef struct packed {
    logic coil_a;
    logic coil_b;
  } scfd_coil_t;
endpackage

// >>> src/scfd_duty_meter.sv
// Purpose: Measures the duty of the incoming speed command.
// Assumes: Input already synchronised to i_sys_clk.
// Notes: A line stuck high for a timeout reads as full duty.
`timescale 1ns/10ps
module scfd_duty_meter import scfd_pkg::*; #(
  parameter int unsigned TIMEOUT_CYC = IN_TIMEOUT_CYC
) (
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  input wire logic i_cmd,
  output logic [DUTY_W-1:0] o_duty
);
  logic cmd_q;
  logic [CNT_W-1:0] hi_q;
  logic [CNT_W-1:0] per_q;
  logic [DUTY_W-1:0] duty_q;
  wire rise = i_cmd & ~cmd_q;
  wire stuck = per_q >= CNT_W'(TIMEOUT_CYC);
  wire [CNT_W+9:0] scaled = (CNT_W+10)'(hi_q) * (CNT_W+10)'(DUTY_FULL);
  wire [CNT_W+9:0] ratio = scaled / (CNT_W+10)'(per_q + 1'b1);

  // ****************************************
  // Period and high-time counters
  // ****************************************
  // Duty is high time over period, so any period from 10 us to 10 ms works.
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cmd_q <= 1'b1; // Idle level of the pin is high, so no false edge follows reset.
      hi_q <= '0;
      per_q <= '0;
      duty_q <= DUTY_FULL;
    end else begin
      cmd_q <= i_cmd;
      if (rise) begin // RULE1
        duty_q <= DUTY_W'(ratio);
        hi_q <= CNT_W'(1);
        per_q <= '0;
      end else if (stuck) begin // RULE4
        duty_q <= i_cmd ? DUTY_FULL : '0;
        per_q <= '0;
        hi_q <= '0;
      end else begin
        per_q <= per_q + 1'b1;
        hi_q <= hi_q + CNT_W'(i_cmd);
      end
    end
  end

  assign o_duty = duty_q;

  // A line held high past the timeout, with no fresh rising edge, must read as full duty.
  property p_stuck_full;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
    (stuck && i_cmd && cmd_q) |=> (duty_q == DUTY_FULL);
  endproperty
  a_stuck_full: assert property (p_stuck_full) else $error("Stuck high line not full duty."); // RULE4
endmodule

// >>> dv/scfd_host_model.sv
// Purpose: Host side PWM command source for the fan drive bench.
// Assumes: Command period of 1000 clocks, which is 100 kHz at 100 MHz.
// Notes: A floating wire is modelled as a line held high by the pull-up.
`timescale 1ns/10ps
module scfd_host_model (
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  input wire logic [9:0] i_high_cyc,
  input wire logic i_float,
  output logic o_speed_cmd
);
  // ****************************************
  // Command carrier
  // ****************************************
  logic [9:0] cnt_q;
  // Free-running period counter; the fastest legal command rate stresses the meter most.
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cnt_q <= 10'h000;
    end else if (cnt_q == 10'h3e7) begin
      cnt_q <= 10'h000;
    end else begin
      cnt_q <= cnt_q + 10'h001;
    end
  end
  // High for the first i_high_cyc clocks of each period, or always when the wire is broken.
  assign o_speed_cmd = i_float | (cnt_q < i_high_cyc);
endmodule

// >>> dv/tb_single_coil_fan_drive_control.sv
// Purpose: Self-checking bench for the fan drive control top.
// Assumes: Shortened start and lock timers; carrier of 4000 clocks.
// Notes: Duty is judged over one carrier once the slope ramp has settled.
`timescale 1ns/10ps
module tb_single_coil_fan_drive_control;
  import scfd_pkg::*;
  localparam int START_T = 3000;
  localparam int HOLD_T = 31000;
  logic i_sys_clk, i_reset_n, i_hall_south, i_min_speed_in, speed_cmd, float_q;
  logic o_coil_drive_a, o_coil_drive_b, o_tach_out_oe;
  logic [9:0] high_cyc;
  logic [15:0] lfsr_q;
  logic [31:0] ca, cb;
  int fails, total_checks;

  scfd_top #(.START_CYC(START_T), .LOCK_ON_CYC(50000), .LOCK_OFF_CYC(4000), .IN_TIMEOUT(2500)) scfd_top_inst (
    .i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n), .i_speed_cmd(speed_cmd), .i_hall_south(i_hall_south),
    .i_min_speed_in(i_min_speed_in), .o_coil_drive_a(o_coil_drive_a), .o_coil_drive_b(o_coil_drive_b),
    .o_tach_out_oe(o_tach_out_oe));
  scfd_host_model scfd_host_model_inst (.i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n),
    .i_high_cyc(high_cyc), .i_float(float_q), .o_speed_cmd(speed_cmd));

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [15:0] lfsr_next(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  // Coil-high clocks over one carrier for a settled duty, with the optional floor.
  function automatic logic [31:0] exp_high(input logic [9:0] duty, input logic floor_on);
    return 32'((floor_on && duty < DUTY_TEN) ? DUTY_TEN : duty) * 32'(OUT_STEP_CYC);
  endfunction
  // Tolerance check written so that an unknown count never passes.
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] tol);
    total_checks++;
    if ((got + tol >= exp && got <= exp + tol) !== 1'b1) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic measure(input int n);
    ca = 0;
    cb = 0;
    repeat (n) begin
      @(negedge i_sys_clk);
      ca += o_coil_drive_a;
      cb += o_coil_drive_b;
    end
  endtask
  task automatic do_reset();
    @(posedge i_sys_clk);
    i_reset_n <= 1'b0;
    repeat (4) @(posedge i_sys_clk);
    i_reset_n <= 1'b1;
  endtask
  task automatic results();
    $display("checks=%0d mismatches=%0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ****************************************
  // Clock, watchdog and pole monitor
  // ****************************************
  initial begin
    i_sys_clk = 1'b0;
    forever #5 i_sys_clk = ~i_sys_clk;
  end
  // The run needs about 86k clocks; 95k leaves margin without hiding a hang.
  initial begin
    #950000;
    fails++;
    results();
  end
  // Coil A may only pulse on a north pole and coil B on a south pole, never both.
  wire [2:0] pole_got = {o_coil_drive_a, o_coil_drive_b, o_tach_out_oe};
  wire [2:0] pole_exp = {o_coil_drive_a & ~o_tach_out_oe, o_coil_drive_b & o_tach_out_oe, o_tach_out_oe};
  always @(negedge i_sys_clk) begin
    if (i_reset_n === 1'b1) begin
      total_checks++;
      if (pole_got !== pole_exp || $isunknown(pole_got)) begin
        fails++;
        $display("BAD t=%0t got=%h exp=%h", $time, pole_got, pole_exp);
      end
    end
  end

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    i_reset_n = 1'b0;
    i_hall_south = 1'b0;
    i_min_speed_in = 1'b0;
    float_q = 1'b1;
    high_cyc = 10'h000;
    lfsr_q = 16'h0045;
    fails = 0;
    total_checks = 0;
    // A rotor that never turns must fall into the off interval after the start window.
    do_reset();
    repeat (START_T + 100) @(posedge i_sys_clk);
    measure(3800);
    check(ca + cb, 32'h0, 32'h0);
    $display("test locked rotor done");
    // Four Hall edges during start, then a random command duty at 100 kHz.
    do_reset();
    lfsr_q = lfsr_next(lfsr_q);
    float_q <= 1'b0;
    high_cyc <= 10'(200 + lfsr_q % 600);
    for (int k = 0; k < 4; k++) begin
      repeat (300) @(posedge i_sys_clk);
      i_hall_south <= ~i_hall_south;
    end
    repeat (HOLD_T) @(posedge i_sys_clk);
    measure(4000);
    check(ca, exp_high(high_cyc, 1'b0), 32'h50);
    check(32'(o_tach_out_oe), 32'h0, 32'h0);
    $display("test random duty done");
    // A 5 percent command with the floor fitted is lifted to 10 percent.
    @(posedge i_sys_clk);
    i_hall_south <= 1'b1;
    i_min_speed_in <= 1'b1;
    high_cyc <= 10'h032;
    repeat (HOLD_T) @(posedge i_sys_clk);
    measure(4000);
    check(cb, exp_high(10'h032, 1'b1), 32'h50);
    check(32'(o_tach_out_oe), 32'h1, 32'h0);
    $display("test floor done");
    // A broken command wire reads high and gives full drive; the pole is kept so no new ramp is needed.
    @(posedge i_sys_clk);
    i_min_speed_in <= 1'b0;
    float_q <= 1'b1;
    repeat (4000) @(posedge i_sys_clk);
    measure(4000);
    check(cb, exp_high(DUTY_FULL, 1'b0), 32'h64);
    $display("test broken wire done");
    results();
  end
endmodule
